// ---- src/slb_pkg.sv ----
/*
 Package of the serial link self-test block: widths, timing counts,
 checker states and the PRBS7 word generator.
 Assumes a 250 MHz core clock and 24-bit payload words.
*/
package slb_pkg;
    localparam int           PAYLOAD_W     = 24;
    localparam int           PRBS_W        = 7;
    localparam int           CLK_BITS_W    = 2;
    localparam logic [6:0]   PRBS_SEED     = 7'h7F;
    // Embedded clock bits: bit one high, bit zero low
    localparam logic [1:0]   CLK_BITS_OK   = 2'h2;
    localparam int           CLK_PERIOD_PS = 4000;
    localparam int           LOSS_TIME_NS  = 64;
    localparam int           LOSS_CYCLES   = (LOSS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int           LOSS_CNT_W    = 8;
    localparam int           LOCK_WORDS    = 4;
    localparam int           LOCK_CNT_W    = 3;
    localparam int           BUF_DEPTH     = 2;

    typedef enum logic [1:0] {CHK_IDLE, CHK_RUN, CHK_DONE} slb_chk_state_t;

    // Advances x^7+x^6+1 by one word; returns {word, next state}
    function automatic logic [PAYLOAD_W+PRBS_W-1:0] slb_prbs_word(input logic [PRBS_W-1:0] s);
        logic [PRBS_W-1:0]    st;
        logic [PAYLOAD_W-1:0] w;
        st = s;
        w  = '0;
        for (int i = PAYLOAD_W - 1; i >= 0; i--) begin
            w[i] = st[6] ^ st[5];
            st   = {st[5:0], w[i]};
        end
        return {w, st};
    endfunction : slb_prbs_word
endpackage : slb_pkg

// ---- src/slb_buf.sv ----
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock; entries are flip-flops, read data muxed from them without a register.
*/
`timescale 1ns/1ps
`default_nettype none
module slb_buf (
    input  wire logic                          core_clk,
    input  wire logic                          arst_n,
    input  wire logic [slb_pkg::PAYLOAD_W-1:0] in_data,
    input  wire logic                          in_valid,
    output logic                               in_ready,
    output logic [slb_pkg::PAYLOAD_W-1:0]      out_data,
    output logic                               out_valid,
    input  wire logic                          out_ready
);
    import slb_pkg::*;

    logic [PAYLOAD_W-1:0] mem_reg [BUF_DEPTH];
    logic                 wr_ptr_reg;
    logic                 rd_ptr_reg;
    logic [1:0]           count_reg;
    wire                  push = in_valid && in_ready;
    wire                  pop  = out_valid && out_ready;

    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem_reg[rd_ptr_reg];

    generate
        for (genvar e = 0; e < BUF_DEPTH; e++) begin : g_entry
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    mem_reg[e] <= '0;
                end else if (push && wr_ptr_reg == 1'(e)) begin
                    mem_reg[e] <= in_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg ^ push;
            rd_ptr_reg <= rd_ptr_reg ^ pop;
            count_reg  <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    a_buf_full_stall: assert property (@(posedge core_clk) disable iff (!arst_n)
        (count_reg == 2'h2 && !out_ready) |=> (count_reg == 2'h2 && !in_ready))
        else $error("full buffer lost or took a word");
    a_buf_keeps_word: assert property (@(posedge core_clk) disable iff (!arst_n)
        (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
        else $error("stalled word lost");
endmodule : slb_buf
`default_nettype wire

// ---- src/slb_bist.sv ----
/*
 Serial link self test: serializer pattern source and deserializer
 checker with pass flag, lock indication and output shut-off.
 Assumes link words arrive synchronous to core_clk, one per rx_valid.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - With the serializer enable high, payload is replaced by a PRBS7 stream sent at full rate.
// - With the deserializer enable high, the received PRBS7 stream is checked for bit errors.
// - Each received payload with one to 24 bit errors drives the pass flag low for one short pulse.
// - Parallel data outputs are switched off once the self-test command is seen; the pattern is not looked at.
// - When the deserializer enable falls, checking stops and the flag shows the final result.
// - The final result is held until a new test starts or the device is reset.
// - Only payload bits are compared; embedded clock bits are judged by the lock indication.
// - Lock drops whenever the embedded clock bits do not form the expected pattern.
// - On loss of the incoming stream lock drops, data outputs switch off and the pass output follows the output state select.
module slb_bist (
    input  wire logic                           core_clk,
    input  wire logic                           arst_n,
    input  wire logic                           ser_self_test_enable,
    input  wire logic [slb_pkg::PAYLOAD_W-1:0]  tx_payload,
    input  wire logic                           tx_valid,
    output logic                                tx_ready,
    input  wire logic                           link_ready,
    output logic [slb_pkg::PAYLOAD_W-1:0]       link_word,
    output logic [slb_pkg::CLK_BITS_W-1:0]      link_clk_bits,
    output logic                                link_bist_cmd,
    output logic                                link_valid,
    input  wire logic                           des_self_test_enable,
    input  wire logic [slb_pkg::PAYLOAD_W-1:0]  rx_word,
    input  wire logic [slb_pkg::CLK_BITS_W-1:0] rx_clk_bits,
    input  wire logic                           rx_bist_cmd,
    input  wire logic                           rx_valid,
    input  wire logic                           output_state_select,
    output logic [slb_pkg::PAYLOAD_W-1:0]       rx_data_out,
    output logic                                rx_data_valid,
    output logic                                rx_data_oe,
    output logic                                test_pass,
    output logic                                test_pass_oe,
    output logic                                link_lock
);
    import slb_pkg::*;

    // Serializer side
    logic [PAYLOAD_W-1:0] buf_data;
    logic                 buf_valid;
    logic                 buf_ready;
    logic [PRBS_W-1:0]    ser_state_reg;
    wire  [PAYLOAD_W+PRBS_W-1:0] ser_gen = slb_prbs_word(ser_state_reg);
    wire                  ser_send_test = ser_self_test_enable && link_ready;
    wire                  ser_send_data = !ser_self_test_enable && link_ready && buf_valid;

    assign buf_ready = link_ready && !ser_self_test_enable;

    slb_buf u_buf (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .in_data   (tx_payload),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_ready)
    );

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ser_state_reg <= PRBS_SEED;
            link_word     <= '0;
            link_clk_bits <= CLK_BITS_OK;
            link_bist_cmd <= 1'b0;
            link_valid    <= 1'b0;
        end else begin
            link_valid    <= ser_send_test || ser_send_data;
            link_bist_cmd <= ser_self_test_enable;
            if (ser_send_test) begin
                link_word     <= ser_gen[PRBS_W +: PAYLOAD_W];
                ser_state_reg <= ser_gen[PRBS_W-1:0];
            end else if (ser_send_data) begin
                link_word <= buf_data;
            end
            if (!ser_self_test_enable) begin
                ser_state_reg <= PRBS_SEED;
            end
        end
    end

    // Deserializer: lock and loss of stream
    logic [LOSS_CNT_W-1:0] loss_cnt_reg;
    logic [LOCK_CNT_W-1:0] good_cnt_reg;
    logic                  bist_seen_reg;
    wire                   clk_bits_bad = rx_valid && (rx_clk_bits != CLK_BITS_OK);
    wire                   stream_lost  = (loss_cnt_reg == LOSS_CNT_W'(LOSS_CYCLES));

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            loss_cnt_reg  <= '0;
            good_cnt_reg  <= '0;
            link_lock     <= 1'b0;
            bist_seen_reg <= 1'b0;
        end else begin
            if (rx_valid) begin
                loss_cnt_reg <= '0;
            end else if (!stream_lost) begin
                loss_cnt_reg <= loss_cnt_reg + 1'b1;
            end
            if (clk_bits_bad || stream_lost) begin
                good_cnt_reg <= '0;
                link_lock    <= 1'b0;
            end else if (rx_valid && good_cnt_reg != LOCK_CNT_W'(LOCK_WORDS)) begin
                good_cnt_reg <= good_cnt_reg + 1'b1;
            end else if (good_cnt_reg == LOCK_CNT_W'(LOCK_WORDS)) begin
                link_lock <= 1'b1;
            end
            if (rx_valid) begin
                bist_seen_reg <= rx_bist_cmd;
            end else if (stream_lost) begin
                bist_seen_reg <= 1'b0;
            end
        end
    end

    // Data outputs off while testing or unlocked; pass output off only when unlocked with output_state_select high
    assign rx_data_oe   = link_lock && !bist_seen_reg;
    assign test_pass_oe = link_lock || !output_state_select;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_data_out   <= '0;
            rx_data_valid <= 1'b0;
        end else begin
            rx_data_valid <= rx_valid && !rx_bist_cmd && link_lock;
            if (rx_valid && !rx_bist_cmd) begin
                rx_data_out <= rx_word;
            end
        end
    end

    // Deserializer: pattern checker
    slb_chk_state_t chk_state_reg;
    slb_chk_state_t chk_state_next;
    logic [PRBS_W-1:0] ref_state_reg;
    logic              aligned_reg;
    logic              err_reg;
    wire  [PAYLOAD_W+PRBS_W-1:0] ref_gen = slb_prbs_word(ref_state_reg);
    wire                  chk_run   = (chk_state_reg == CHK_RUN);
    wire                  chk_word  = chk_run && rx_valid && rx_bist_cmd;
    wire                  word_err  = chk_word && aligned_reg
                                      && (rx_word != ref_gen[PRBS_W +: PAYLOAD_W]);
    wire                  err_any   = err_reg || word_err;
    wire                  test_start = !chk_run && des_self_test_enable;
    wire                  test_stop  = chk_run && !des_self_test_enable;

    always_comb begin
        chk_state_next = chk_state_reg;
        case (chk_state_reg)
            CHK_IDLE: begin
                if (des_self_test_enable) chk_state_next = CHK_RUN;
            end
            CHK_RUN: begin
                if (!des_self_test_enable) chk_state_next = CHK_DONE;
            end
            CHK_DONE: begin
                if (des_self_test_enable) chk_state_next = CHK_RUN;
            end
            default: chk_state_next = CHK_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            chk_state_reg <= CHK_IDLE;
            ref_state_reg <= PRBS_SEED;
            aligned_reg   <= 1'b0;
            err_reg       <= 1'b0;
            test_pass     <= 1'b1;
        end else begin
            chk_state_reg <= chk_state_next;
            if (!chk_run) begin
                aligned_reg <= 1'b0;
            end else if (chk_word && !aligned_reg) begin
                ref_state_reg <= rx_word[PRBS_W-1:0];
                aligned_reg   <= 1'b1;
            end else if (chk_word) begin
                ref_state_reg <= ref_gen[PRBS_W-1:0];
            end
            if (test_start) begin
                err_reg   <= 1'b0;
                test_pass <= 1'b1;
            end else if (test_stop) begin
                test_pass <= !err_any;
            end else if (chk_run) begin
                err_reg   <= err_any;
                test_pass <= !word_err;
            end
        end
    end

    a_pass_pulse_low: assert property (@(posedge core_clk) disable iff (!arst_n)
        (word_err && des_self_test_enable) |=> !test_pass)
        else $error("errored payload gave no low pulse");
    a_pass_final_result: assert property (@(posedge core_clk) disable iff (!arst_n)
        test_stop |=> (test_pass == !$past(err_any)))
        else $error("final result wrong");
    a_pass_result_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        (chk_state_reg == CHK_DONE && !des_self_test_enable) |=> $stable(test_pass))
        else $error("held result changed");
    a_start_clears_err: assert property (@(posedge core_clk) disable iff (!arst_n)
        test_start |=> (test_pass && !err_reg) ##1 (chk_state_reg == CHK_RUN || !des_self_test_enable))
        else $error("new test did not start clean");
    a_outputs_shut_off: assert property (@(posedge core_clk) disable iff (!arst_n)
        (rx_valid && rx_bist_cmd) |=> !rx_data_oe && !rx_data_valid)
        else $error("outputs active during test");
    a_lock_clock_bits: assert property (@(posedge core_clk) disable iff (!arst_n)
        clk_bits_bad |=> !link_lock [*2])
        else $error("lock held with bad clock bits");
    a_lock_stream_loss: assert property (@(posedge core_clk) disable iff (!arst_n)
        stream_lost |=> !link_lock && !rx_data_oe && (test_pass_oe == !output_state_select))
        else $error("stream loss not handled");
    a_ser_sends_prbs: assert property (@(posedge core_clk) disable iff (!arst_n)
        ser_send_test |=> link_valid && link_bist_cmd && (link_word == $past(ser_gen[PRBS_W +: PAYLOAD_W])))
        else $error("serializer did not send pattern");
    a_clean_word_passes: assert property (@(posedge core_clk) disable iff (!arst_n)
        (chk_word && aligned_reg && rx_word == ref_gen[PRBS_W +: PAYLOAD_W] && !err_reg
         && des_self_test_enable) |=> test_pass)
        else $error("clean word flagged");

    c_error_seen:  cover property (@(posedge core_clk) disable iff (!arst_n) word_err ##1 !test_pass);
    c_clean_pass:  cover property (@(posedge core_clk) disable iff (!arst_n) test_stop && !err_any);
    c_failed_test: cover property (@(posedge core_clk) disable iff (!arst_n) test_stop && err_reg);
    c_lock_lost:   cover property (@(posedge core_clk) disable iff (!arst_n) link_lock ##1 !link_lock);
endmodule : slb_bist
`default_nettype wire

// ---- verif/slb_link_model.sv ----
/*
 Far-side link model: loops serializer words back to the deserializer input one cycle later.
 Assumes one core clock; stalls and one-shot payload or clock-bit faults come from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module slb_link_model (
    input  wire logic                           core_clk,
    input  wire logic                           arst_n,
    input  wire logic                           stall,
    input  wire logic                           inj,
    input  wire logic [slb_pkg::PAYLOAD_W:0]    inj_mask,
    input  wire logic [slb_pkg::PAYLOAD_W-1:0]  link_word,
    input  wire logic [slb_pkg::CLK_BITS_W-1:0] link_clk_bits,
    input  wire logic                           link_bist_cmd,
    input  wire logic                           link_valid,
    output logic                                link_ready,
    output logic [slb_pkg::PAYLOAD_W-1:0]       rx_word,
    output logic [slb_pkg::CLK_BITS_W-1:0]      rx_clk_bits,
    output logic                                rx_bist_cmd,
    output logic                                rx_valid
);
    import slb_pkg::*;
    logic [PAYLOAD_W:0] pend_reg;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_reg    <= '0;
            link_ready  <= 1'b0;
            rx_valid    <= 1'b0;
            rx_word     <= '0;
            rx_clk_bits <= '0;
            rx_bist_cmd <= 1'b0;
        end else begin
            link_ready <= ~stall;
            rx_valid   <= link_valid;
            if (inj) begin
                pend_reg <= inj_mask;
            end else if (link_valid) begin
                pend_reg <= '0;
            end
            // Released lines show the inverse of their last value
            if (link_valid) begin
                rx_word     <= link_word ^ pend_reg[PAYLOAD_W-1:0];
                rx_clk_bits <= pend_reg[PAYLOAD_W] ? ~link_clk_bits : link_clk_bits;
                rx_bist_cmd <= link_bist_cmd;
            end else begin
                rx_word     <= ~rx_word;
                rx_clk_bits <= ~rx_clk_bits;
                rx_bist_cmd <= ~rx_bist_cmd;
            end
        end
    end
endmodule : slb_link_model
`default_nettype wire

// ---- verif/slb_bist_bench.sv ----
/*
 Bench of the link self test: loopback partner, word FIFO and PRBS7 models, pulse counts.
 Assumes the package, design and link model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module slb_bist_bench;
    import slb_pkg::*;
    logic                  core_clk = 1'b0;
    logic                  arst_n = 1'b0;
    logic                  ser_self_test_enable = 1'b0;
    logic                  des_self_test_enable = 1'b0;
    logic                  output_state_select = 1'b0;
    logic                  tx_valid = 1'b0;
    logic                  stall = 1'b0;
    logic                  inj = 1'b0;
    logic [PAYLOAD_W-1:0]  tx_payload = '0;
    logic [PAYLOAD_W:0]    inj_mask = '0;
    logic [PAYLOAD_W-1:0]  link_word, rx_word, rx_data_out;
    logic [CLK_BITS_W-1:0] link_clk_bits, rx_clk_bits;
    logic                  tx_ready, link_ready, link_bist_cmd, link_valid, rx_bist_cmd, rx_valid;
    logic                  rx_data_valid, rx_data_oe, test_pass, test_pass_oe, link_lock;
    logic [31:0]           rnd = 32'hf6f0;
    logic [6:0]            prbs = 7'h7f;
    logic [PAYLOAD_W-1:0]  exp_rx = '0;
    logic [PAYLOAD_W-1:0]  txq[$];
    int                    fails = 0, checks = 0, lows = 0, dv_run = 0, unlocked = 0;
    bit                    run_on = 1'b0;

    always #2 core_clk = ~core_clk;

    slb_bist dut_u (.core_clk(core_clk), .arst_n(arst_n), .ser_self_test_enable(ser_self_test_enable),
        .tx_payload(tx_payload), .tx_valid(tx_valid), .tx_ready(tx_ready), .link_ready(link_ready),
        .link_word(link_word), .link_clk_bits(link_clk_bits), .link_bist_cmd(link_bist_cmd),
        .link_valid(link_valid), .des_self_test_enable(des_self_test_enable), .rx_word(rx_word),
        .rx_clk_bits(rx_clk_bits), .rx_bist_cmd(rx_bist_cmd), .rx_valid(rx_valid),
        .output_state_select(output_state_select), .rx_data_out(rx_data_out), .rx_data_valid(rx_data_valid),
        .rx_data_oe(rx_data_oe), .test_pass(test_pass), .test_pass_oe(test_pass_oe), .link_lock(link_lock));

    slb_link_model link_u (.core_clk(core_clk), .arst_n(arst_n), .stall(stall), .inj(inj),
        .inj_mask(inj_mask), .link_word(link_word), .link_clk_bits(link_clk_bits),
        .link_bist_cmd(link_bist_cmd), .link_valid(link_valid), .link_ready(link_ready),
        .rx_word(rx_word), .rx_clk_bits(rx_clk_bits), .rx_bist_cmd(rx_bist_cmd), .rx_valid(rx_valid));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out;
        if (fails == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out

    task automatic guard(input bit ok);
        if (!ok) begin
            fails++;
            close_out();
        end
    endtask : guard

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge core_clk);
            rnd = xs(rnd);
            stall <= (rnd[1:0] == 2'h0);
        end
    endtask : tick

    task automatic raise;
        tx_valid   <= 1'b1;
        tx_payload <= rnd[PAYLOAD_W-1:0];
    endtask : raise

    task automatic await_take;
        logic r;
        r = 1'b0;
        for (int i = 0; i < 200 && r !== 1'b1; i++) begin
            @(negedge core_clk);
            r = tx_ready;
            tick(1);
        end
        guard(r === 1'b1);
        txq.push_back(tx_payload);
    endtask : await_take

    task automatic drain;
        for (int i = 0; i < 300 && txq.size() != 0; i++) tick(1);
        guard(txq.size() == 0);
    endtask : drain

    task automatic wait_lock;
        for (int i = 0; i < 60; i++) begin
            tick(1);
            @(negedge core_clk);
            if (link_lock === 1'b1) break;
        end
        guard(link_lock === 1'b1);
    endtask : wait_lock

    task automatic pulse_fault(input logic [PAYLOAD_W:0] m);
        inj_mask <= m;
        inj      <= 1'b1;
        tick(1);
        inj      <= 1'b0;
    endtask : pulse_fault

    // Tx word order, PRBS7 words, rx data and run counters
    always @(negedge core_clk) begin : mon
        logic [PAYLOAD_W-1:0] w;
        if (arst_n && link_valid === 1'b1) begin
            if (link_bist_cmd) begin
                for (int i = PAYLOAD_W - 1; i >= 0; i--) begin
                    w[i] = prbs[6] ^ prbs[5];
                    prbs = {prbs[5:0], w[i]};
                end
                check("prbs word", 32'(link_word), 32'(w));
            end else begin
                guard(txq.size() != 0);
                check("link word", 32'(link_word), 32'(txq.pop_front()));
            end
            check("clock bits", 32'(link_clk_bits), 32'(CLK_BITS_OK));
        end
        if (link_bist_cmd !== 1'b1) prbs = 7'h7f;
        if (rx_data_valid === 1'b1) check("rx data", 32'(rx_data_out), 32'(exp_rx));
        if (rx_valid && !rx_bist_cmd) exp_rx = rx_word;
        if (run_on && test_pass !== 1'b1) lows++;
        if (run_on && rx_data_valid !== 1'b0) dv_run++;
        if (run_on && link_lock !== 1'b1) unlocked++;
    end

    task automatic run_test(input int nerr);
        tick(1);
        ser_self_test_enable <= 1'b1;
        tick(6);
        des_self_test_enable <= 1'b1;
        tick(3);
        @(negedge core_clk);
        check("pass at start", 32'(test_pass), 1);
        lows   = 0;
        dv_run = 0;
        run_on = 1'b1;
        tick(8);
        for (int i = 0; i <= nerr; i++) begin
            if (i == nerr) unlocked = 0;
            pulse_fault((i == nerr) ? 25'h100_0000 : (i == 0) ? 25'h0001 :
                        (i == 1) ? 25'hff_ffff : {1'b0, rnd[PAYLOAD_W-1:0] | 24'h00_0001});
            tick(9);
        end
        check("lock dropped", 32'(unlocked > 0), 1);
        wait_lock();
        check("data oe off", 32'(rx_data_oe), 0);
        tick(4);
        run_on = 1'b0;
        check("error pulses", 32'(lows), 32'(nerr));
        check("no data in test", 32'(dv_run), 0);
        des_self_test_enable <= 1'b0;
        tick(3);
        @(negedge core_clk);
        check("final", 32'(test_pass), 32'(nerr == 0));
        tick(1);
        pulse_fault(25'h0010);
        tick(20);
        @(negedge core_clk);
        check("held", 32'(test_pass), 32'(nerr == 0));
        tick(1);
        ser_self_test_enable <= 1'b0;
        tick(4);
    endtask : run_test

    initial begin
        @(negedge core_clk);
        check("reset pass", 32'(test_pass), 1);
        check("reset lock", 32'(link_lock), 0);
        check("reset ready", 32'(tx_ready), 1);
        tick(3);
        arst_n <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            tick(1);
            output_state_select <= k[0];
            tick(2);
            burst(10);
            drain();
            @(negedge core_clk);
            check("lock", 32'(link_lock), 1);
            check("data oe", 32'(rx_data_oe), 1);
            check("pass oe", 32'(test_pass_oe), 1);
            tick(LOSS_CYCLES + 4);
            @(negedge core_clk);
            check("lock lost", 32'(link_lock), 0);
            check("pass oe idle", 32'(test_pass_oe), 32'(!output_state_select));
        end
        tick(1);
        ser_self_test_enable <= 1'b1;
        tick(4);
        burst(2);
        tick(1);
        raise();
        repeat (3) begin
            @(negedge core_clk);
            check("refused", 32'(tx_ready), 0);
        end
        tick(1);
        ser_self_test_enable <= 1'b0;
        await_take();
        tx_valid <= 1'b0;
        drain();
        run_test(3);
        run_test(0);
        run_test(1);
        tick(1);
        arst_n <= 1'b0;
        tick(2);
        @(negedge core_clk);
        check("pass after reset", 32'(test_pass), 1);
        tick(1);
        arst_n <= 1'b1;
        tick(4);
        close_out();
    end

    task automatic burst(input int n);
        repeat (n) begin
            raise();
            await_take();
        end
        tx_valid <= 1'b0;
    endtask : burst

    initial begin
        repeat (100000) @(posedge core_clk);
        guard(1'b0);
    end
endmodule : slb_bist_bench
`default_nettype wire
